/* verilog/swire_rx_defines.svh */
// Offsets, reset values and timing counts of the pulse-count rail programmer
`ifndef SWIRE_RX_DEFINES_SVH
`define SWIRE_RX_DEFINES_SVH

// Clock period of ref_clk_i (10 MHz)
`define SW_CLK_PERIOD_NS   100
// Least low time of a falling edge before it counts as a pulse
`define SW_FILT_LOW_NS     500
`define SW_FILT_LOW_CYC    ((`SW_FILT_LOW_NS + `SW_CLK_PERIOD_NS - 1) / `SW_CLK_PERIOD_NS)
// Idle gap that ends a frame (high) or switches the rail off (low)
`define SW_STOP_GAP_NS     50000
`define SW_STOP_GAP_CYC    ((`SW_STOP_GAP_NS + `SW_CLK_PERIOD_NS - 1) / `SW_CLK_PERIOD_NS)
// Level codes: count 1 is -5.4 V, each step +100 mV, count 6 is the default
`define SW_CODE_MIN        5'h01
`define SW_CODE_MAX        5'h1f
`define SW_CODE_DEFAULT    5'h06
`define SW_LEVEL_BASE_MV   (-5400)
`define SW_LEVEL_STEP_MV   100
// Level of the default code 6 (-4900 mV), used as the reset value
`define SW_LEVEL_RESET_MV  16'shecdc

`endif

/* verilog/swire_rx_pkg.sv */
// Types of the pulse-count rail programmer
package swire_rx_pkg;

  // Regulation mode of the negative rail
  typedef enum logic [1:0] {
    RAIL_OFF     = 2'b00,
    RAIL_DEFAULT = 2'b01,
    RAIL_PROG    = 2'b10
  } rail_mode_t;

  // Line receiver state
  typedef enum logic [0:0] {
    LINK_HIGH = 1'b0,
    LINK_LOW  = 1'b1
  } link_state_t;

  // Rail setting handed to the converter
  typedef struct packed {
    rail_mode_t         mode;
    logic [4:0]         code;
    logic signed [15:0] level_mv;
  } rail_status_t;

endpackage : swire_rx_pkg

/* verilog/pulse_count_negative_rail_programmer.sv */
// Pulse-count receiver that sets the negative rail level
// Operation
// - Frames are pulse trains, bounded by start and stop, decoded in real time.
// - No clock line; each pulse is recognised from its own timing.
// - Count n in 1..31 selects -5.4 V plus (n-1) times 100 mV.
// - Enable pin high forces the default level, count 6, -4.9 V.
// - Enable low, line high follows count; both low for the stop gap switches the rail off.
// - Falling edges pass a low-pass filter before they count as pulses.
`include "swire_rx_defines.svh"

module pulse_count_negative_rail_programmer #(
  parameter int unsigned FILT_CYC = `SW_FILT_LOW_CYC,
  parameter int unsigned STOP_CYC = `SW_STOP_GAP_CYC
) (
  // Clock, reset and enable
  input  wire logic               ref_clk_i,
  input  wire logic               nrst_i,
  input  wire logic               clk_en_i,
  // Pins from the controller
  input  wire logic               pulse_program_line_i,
  input  wire logic               power_enable_pin_i,
  // Rail setting and count reject strobe
  output swire_rx_pkg::rail_status_t rail_status_o,
  output logic                    count_reject_o
);

  localparam int unsigned TW = $clog2(STOP_CYC + 1);

  // Millivolt level of a code; codes outside 1..31 never reach it
  function automatic logic signed [15:0] code_to_mv(input logic [4:0] code);
    code_to_mv = 16'(`SW_LEVEL_BASE_MV + (int'(code) - 1) * `SW_LEVEL_STEP_MV);
  endfunction : code_to_mv

  logic                      line_meta_reg;
  logic                      line_sync_reg;
  logic                      en_meta_reg;
  logic                      en_sync_reg;
  swire_rx_pkg::link_state_t link_state_reg;
  logic [TW-1:0]             timer_reg;
  logic [5:0]                pulse_cnt_reg;
  logic                      long_low_reg;
  logic [4:0]                prog_code_reg;
  logic                      frame_end;
  logic                      frame_ok;
  swire_rx_pkg::rail_status_t status_next;

  // Pins are asynchronous to ref_clk_i, so two flops before any use
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_meta_reg <= 1'b1;
      line_sync_reg <= 1'b1;
      en_meta_reg   <= 1'b0;
      en_sync_reg   <= 1'b0;
    end else if (clk_en_i) begin
      line_meta_reg <= pulse_program_line_i;
      line_sync_reg <= line_meta_reg;
      en_meta_reg   <= power_enable_pin_i;
      en_sync_reg   <= en_meta_reg;
    end
  end

  // Frame ends when the line has idled high for the stop gap with pulses seen
  assign frame_end = (link_state_reg == swire_rx_pkg::LINK_HIGH) && line_sync_reg &&
                     (timer_reg == TW'(STOP_CYC - 1)) && (pulse_cnt_reg != 6'h00);
  assign frame_ok  = (pulse_cnt_reg >= 6'(`SW_CODE_MIN)) &&
                     (pulse_cnt_reg <= 6'(`SW_CODE_MAX));

  // Line receiver: level timer restarts on every accepted level change
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_state_reg <= swire_rx_pkg::LINK_HIGH;
      timer_reg      <= '0;
    end else if (clk_en_i) begin
      case (link_state_reg)
        swire_rx_pkg::LINK_HIGH: begin
          if (!line_sync_reg) begin
            link_state_reg <= swire_rx_pkg::LINK_LOW;
            timer_reg      <= '0;
          end else if (timer_reg != TW'(STOP_CYC - 1)) begin
            timer_reg <= timer_reg + 1'b1;
          end
        end
        swire_rx_pkg::LINK_LOW: begin
          if (line_sync_reg) begin
            link_state_reg <= swire_rx_pkg::LINK_HIGH;
            timer_reg      <= '0;
          end else if (timer_reg != TW'(STOP_CYC - 1)) begin
            timer_reg <= timer_reg + 1'b1;
          end
        end
        default: begin
          link_state_reg <= swire_rx_pkg::LINK_HIGH;
          timer_reg      <= '0;
        end
      endcase
    end
  end

  // Pulse counter: a low counts only once it outlives the filter time,
  // so spikes shorter than that leave the count untouched
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pulse_cnt_reg <= 6'h00;
    end else if (clk_en_i) begin
      if (frame_end) begin
        pulse_cnt_reg <= 6'h00;
      end else if (link_state_reg == swire_rx_pkg::LINK_LOW && !line_sync_reg) begin
        if (timer_reg == TW'(FILT_CYC - 1) && pulse_cnt_reg != 6'h3f) begin
          pulse_cnt_reg <= pulse_cnt_reg + 6'h01;
        end else if (timer_reg == TW'(STOP_CYC - 1)) begin
          pulse_cnt_reg <= 6'h00; // Held low: abandon the frame
        end
      end
    end
  end

  // Long low marks the rail-off request; any high clears it
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      long_low_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (line_sync_reg) begin
        long_low_reg <= 1'b0;
      end else if (link_state_reg == swire_rx_pkg::LINK_LOW &&
                   timer_reg == TW'(STOP_CYC - 1)) begin
        long_low_reg <= 1'b1;
      end
    end
  end

  // Programmed code: latched at frame end, back to default once switched off
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prog_code_reg  <= `SW_CODE_DEFAULT;
      count_reject_o <= 1'b0;
    end else if (clk_en_i) begin
      count_reject_o <= frame_end && !frame_ok;
      if (frame_end && frame_ok) begin
        prog_code_reg <= pulse_cnt_reg[4:0];
      end else if (!en_sync_reg && long_low_reg) begin
        prog_code_reg <= `SW_CODE_DEFAULT;
      end
    end
  end

  // Mode decision; a short low inside a frame keeps the previous setting
  always_comb begin
    status_next = rail_status_o;
    if (en_sync_reg) begin
      status_next.mode = swire_rx_pkg::RAIL_DEFAULT;
      status_next.code = `SW_CODE_DEFAULT;
    end else if (line_sync_reg) begin
      status_next.mode = swire_rx_pkg::RAIL_PROG;
      status_next.code = prog_code_reg;
    end else if (long_low_reg) begin
      status_next.mode = swire_rx_pkg::RAIL_OFF;
      status_next.code = `SW_CODE_DEFAULT;
    end
    status_next.level_mv = code_to_mv(status_next.code);
  end

  // Registered rail setting
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rail_status_o <= '{mode: swire_rx_pkg::RAIL_OFF, code: `SW_CODE_DEFAULT,
                         level_mv: `SW_LEVEL_RESET_MV};
    end else if (clk_en_i) begin
      rail_status_o <= status_next;
    end
  end

  AST_DEFAULT_WHEN_EN: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    clk_en_i && en_sync_reg |=> rail_status_o.mode == swire_rx_pkg::RAIL_DEFAULT &&
      rail_status_o.code == 5'h06 && rail_status_o.level_mv == -16'sd4900)
    else $error("default level not applied while enable high");

  AST_PROG_FOLLOWS: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    clk_en_i && !en_sync_reg && line_sync_reg |=>
      rail_status_o.mode == swire_rx_pkg::RAIL_PROG &&
      rail_status_o.code == $past(prog_code_reg))
    else $error("rail does not follow programmed count");

  AST_OFF_CAUSE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $rose(rail_status_o.mode == swire_rx_pkg::RAIL_OFF) |->
      !$past(en_sync_reg) && !$past(line_sync_reg) && $past(long_low_reg))
    else $error("rail switched off without both pins low");

  AST_LEVEL_MAP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rail_status_o.mode != swire_rx_pkg::RAIL_OFF |->
      rail_status_o.level_mv == -16'sd5400 + 16'(rail_status_o.code - 5'h01) * 16'sd100)
    else $error("level does not match code");

  AST_CODE_RANGE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    prog_code_reg >= 5'h01)
    else $error("programmed code out of range");

  AST_GLITCH_IGNORED: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    clk_en_i && link_state_reg == swire_rx_pkg::LINK_LOW && line_sync_reg &&
      timer_reg < TW'(FILT_CYC - 1) ##1 clk_en_i && line_sync_reg [*3] |->
      pulse_cnt_reg == $past(pulse_cnt_reg, 3))
    else $error("short low was counted as a pulse");

  // A count step must follow several synced low cycles; a broken filter
  // would step on the first low sample
  AST_COUNT_NEEDS_LOW: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    pulse_cnt_reg != $past(pulse_cnt_reg) && pulse_cnt_reg != 6'h00 |->
      !$past(line_sync_reg, 1) && !$past(line_sync_reg, 2) && !$past(line_sync_reg, 3))
    else $error("pulse counted without a filtered low");

  AST_LATCH_COUNT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    clk_en_i && frame_end && frame_ok |=>
      prog_code_reg == $past(pulse_cnt_reg[4:0]) && pulse_cnt_reg == 6'h00)
    else $error("valid count not latched at frame end");

  AST_REJECT_COUNT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    clk_en_i && frame_end && !frame_ok |=> count_reject_o && $stable(prog_code_reg))
    else $error("count above 31 changed the level");

endmodule : pulse_count_negative_rail_programmer

/* testbench/pulse_line_driver.sv */
// Controller model that drives the pulse programming line
module pulse_line_driver (
  // Clock
  input  wire logic ref_clk_i,
  // Line to the device
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // 20 low plus 20 high cycles keeps the rate at 250 kHz
  localparam int PULSE_CYC = 20;

  // Idle high; only this model drives the line
  initial line_o = 1'b1;

  // Steady level, changed just after a falling edge
  task automatic set_line(input logic v);
    line_o = v;
  endtask : set_line

  // One low pulse then a high gap shorter than the stop gap
  task automatic pulse(input int low_cyc);
    line_o = 1'b0;
    repeat (low_cyc) @(negedge ref_clk_i);
    line_o = 1'b1;
    repeat (PULSE_CYC) @(negedge ref_clk_i);
  endtask : pulse

  // Frame of n pulses; the glitch after the first is too short to count
  task automatic send(input int n, input bit glitch);
    for (int i = 0; i < n; i++) begin
      pulse(PULSE_CYC);
      if (glitch && i == 0) pulse(1);
    end
  endtask : send
endmodule : pulse_line_driver

/* testbench/pulse_count_negative_rail_programmer_tb.sv */
// Testbench of the pulse-count negative rail programmer
module pulse_count_negative_rail_programmer_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int STOP = 60;
  logic                       ref_clk_i;
  logic                       nrst_i;
  logic                       en_pin;
  logic                       line;
  logic                       clk_en;
  swire_rx_pkg::rail_status_t rail_status_o;
  logic                       count_reject_o;
  int                         n_fail = 0;
  int                         tests_run = 0;
  int                         rej_seen = 0;
  int                         codes[5] = '{1, 2, 31, 6, 17};

  // Shortened filter and stop gap keep the run brief
  pulse_count_negative_rail_programmer #(.FILT_CYC(3), .STOP_CYC(STOP))
    i_pulse_count_negative_rail_programmer (
    .ref_clk_i           (ref_clk_i),
    .nrst_i              (nrst_i),
    .clk_en_i            (clk_en),
    .pulse_program_line_i(line),
    .power_enable_pin_i  (en_pin),
    .rail_status_o       (rail_status_o),
    .count_reject_o      (count_reject_o)
  );
  pulse_line_driver i_pulse_line_driver (.ref_clk_i(ref_clk_i), .line_o(line));

  // 10 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  // Reject strobe lasts one cycle; sampled mid-cycle, away from its launch edge
  always @(negedge ref_clk_i) if (count_reject_o === 1'b1) rej_seen++;

  function automatic logic [22:0] rail(input swire_rx_pkg::rail_mode_t m, input int n);
    swire_rx_pkg::rail_status_t s;
    s.mode = m;
    s.code = n[4:0];
    s.level_mv = 16'(-5400 + (n - 1) * 100);
    return s;
  endfunction : rail

  task automatic check(input logic [22:0] seen, input logic [22:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic settle(input int c);
    repeat (c) @(negedge ref_clk_i);
  endtask : settle

  task automatic frame(input int n, input bit g, input int exp);
    i_pulse_line_driver.send(n, g);
    settle(STOP + 10); // Stop gap plus sync and output latency
    check(rail_status_o, rail(swire_rx_pkg::RAIL_PROG, exp));
  endtask : frame

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // Hang guard, well beyond the expected 4400 or so cycles
  initial begin
    settle(20000);
    n_fail++;
    close_out();
  end

  // Reset holds the rail off; release with the line idle high gives count 6
  task automatic reset_check();
    nrst_i = 1'b0;
    en_pin = 1'b0;
    clk_en = 1'b1;
    settle(20);
    check(rail_status_o, rail(swire_rx_pkg::RAIL_OFF, 6));
    nrst_i = 1'b1;
    settle(5);
    check(rail_status_o, rail(swire_rx_pkg::RAIL_PROG, 6));
  endtask : reset_check

  // Boundary counts, a filtered glitch, then an oversized frame
  task automatic count_sweep();
    foreach (codes[i]) frame(codes[i], 1'b0, codes[i]);
    frame(4, 1'b1, 4);
    frame(32, 1'b0, 4);
    check(23'(rej_seen), 23'd1);
  endtask : count_sweep

  // Enable high forces the default whatever the line does
  task automatic enable_default();
    en_pin = 1'b1;
    settle(5);
    check(rail_status_o, rail(swire_rx_pkg::RAIL_DEFAULT, 6));
    i_pulse_line_driver.set_line(1'b0);
    settle(STOP + 10);
    check(rail_status_o, rail(swire_rx_pkg::RAIL_DEFAULT, 6));
  endtask : enable_default

  // Both pins low switches off; line high then returns to count 6
  task automatic rail_off();
    en_pin = 1'b0;
    settle(STOP + 10);
    check(rail_status_o, rail(swire_rx_pkg::RAIL_OFF, 6));
    i_pulse_line_driver.set_line(1'b1);
    settle(5);
    check(rail_status_o, rail(swire_rx_pkg::RAIL_PROG, 6));
  endtask : rail_off

  // Clock enable low freezes the synchronisers and the rail setting
  task automatic freeze_check();
    clk_en = 1'b0;
    en_pin = 1'b1;
    settle(10);
    check(rail_status_o, rail(swire_rx_pkg::RAIL_PROG, 6));
    clk_en = 1'b1;
    settle(5);
    check(rail_status_o, rail(swire_rx_pkg::RAIL_DEFAULT, 6));
    en_pin = 1'b0;
    settle(5);
    check(rail_status_o, rail(swire_rx_pkg::RAIL_PROG, 6));
  endtask : freeze_check

  initial begin
    reset_check();
    count_sweep();
    enable_default();
    rail_off();
    freeze_check();
    close_out();
  end
endmodule : pulse_count_negative_rail_programmer_tb
